// ### hdl/bsp_defines.svh
// bsp_defines.svh: strap codes, reset values and pad indices for the strap/pin-mux block
// assumes: included by bare name from the design modules
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// ----------------------------------------------------------------------------
// operation-mode strap codes
// ----------------------------------------------------------------------------
`define BSP_MODE_DEV_100    3'h0
`define BSP_MODE_DEV_133    3'h1
`define BSP_MODE_DEV_150    3'h2
`define BSP_MODE_HOST_100   3'h4
`define BSP_MODE_HOST_133   3'h5
`define BSP_MODE_HOST_150   3'h6
`define BSP_MODE_RESET      3'h2
`define BSP_MODE_HOST_BIT   2

// ----------------------------------------------------------------------------
// rate codes, reference clock, control register bits
// ----------------------------------------------------------------------------
`define BSP_RATE_100        2'h0
`define BSP_RATE_133        2'h1
`define BSP_RATE_150        2'h2
`define BSP_RATE_BAD        2'h3
`define BSP_REFCLK_25M      2'h1
`define BSP_CTRL_BIT_A      3
`define BSP_CTRL_BIT_B      4
`define BSP_CTRL_BIT_C      5
`define BSP_PIO_STRETCH_MIN 3'h3

// ----------------------------------------------------------------------------
// parallel ATA signal indices, data bits are 0..15
// ----------------------------------------------------------------------------
`define BSP_NUM_ATA         30
`define BSP_IDX_CS0N        16
`define BSP_IDX_CS1N        17
`define BSP_IDX_DA0         18
`define BSP_IDX_DA1         19
`define BSP_IDX_DA2         20
`define BSP_IDX_RDN         21
`define BSP_IDX_WRN         22
`define BSP_IDX_DACKN       23
`define BSP_IDX_DREQ        24
`define BSP_IDX_INTR        25
`define BSP_IDX_RSTN        26
`define BSP_IDX_SPH         27
`define BSP_IDX_RDY         28
`define BSP_IDX_ACTN        29

`endif

// ### hdl/bsp_pad_swap.sv
// bsp_pad_swap.sv: registered normal/reversed pad order for the parallel ATA signals
// assumes: one clock, reverse and enable held stable while running
`timescale 1ns/10ps
`default_nettype none
`include "bsp_defines.svh"

module bsp_pad_swap
    import bsp_pkg::*;
#(
    parameter int N = `BSP_NUM_ATA
)(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // control
    input  wire logic         reverseOrder,
    input  wire logic         outEnable,
    // core side, logical signal order
    input  wire logic [N-1:0] coreOut,
    input  wire logic [N-1:0] coreOe,
    output var  logic [N-1:0] coreIn,
    // pad side, physical order
    input  wire logic [N-1:0] padIn,
    output var  logic [N-1:0] padOut,
    output var  logic [N-1:0] padOe
);

    // mirror partner of each signal except RDY and ACTN, which keep their place; the mapping is its own inverse
    function automatic int mirrorIdx(input int i);
        case (i)
            0:                mirrorIdx = 13;
            13:               mirrorIdx = 0;
            2:                mirrorIdx = 15;
            15:               mirrorIdx = 2;
            1:                mirrorIdx = 14;
            14:               mirrorIdx = 1;
            12:               mirrorIdx = `BSP_IDX_DREQ;
            `BSP_IDX_DREQ:    mirrorIdx = 12;
            3:                mirrorIdx = `BSP_IDX_WRN;
            `BSP_IDX_WRN:     mirrorIdx = 3;
            11:               mirrorIdx = `BSP_IDX_RDN;
            `BSP_IDX_RDN:     mirrorIdx = 11;
            4:                mirrorIdx = `BSP_IDX_DACKN;
            `BSP_IDX_DACKN:   mirrorIdx = 4;
            10:               mirrorIdx = `BSP_IDX_INTR;
            `BSP_IDX_INTR:    mirrorIdx = 10;
            5:                mirrorIdx = `BSP_IDX_SPH;
            `BSP_IDX_SPH:     mirrorIdx = 5;
            9:                mirrorIdx = `BSP_IDX_DA1;
            `BSP_IDX_DA1:     mirrorIdx = 9;
            6:                mirrorIdx = `BSP_IDX_DA0;
            `BSP_IDX_DA0:     mirrorIdx = 6;
            8:                mirrorIdx = `BSP_IDX_DA2;
            `BSP_IDX_DA2:     mirrorIdx = 8;
            7:                mirrorIdx = `BSP_IDX_CS0N;
            `BSP_IDX_CS0N:    mirrorIdx = 7;
            `BSP_IDX_RSTN:    mirrorIdx = `BSP_IDX_CS1N;
            `BSP_IDX_CS1N:    mirrorIdx = `BSP_IDX_RSTN;
            default:          mirrorIdx = i;
        endcase
    endfunction : mirrorIdx

    logic [N-1:0] padOut_d;
    logic [N-1:0] padOe_d;
    logic [N-1:0] coreIn_d;

    // ------------------------------------------------------------------------
    // per-position select
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_pos
            localparam int M = mirrorIdx(i);
            assign padOut_d[i] = reverseOrder ? coreOut[M] : coreOut[i];
            assign padOe_d[i]  = outEnable & (reverseOrder ? coreOe[M] : coreOe[i]);
            assign coreIn_d[i] = reverseOrder ? padIn[M] : padIn[i];
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            padOut <= '0;
            padOe  <= '0;
            coreIn <= '0;
        end
        else
        begin
            padOut <= padOut_d;
            padOe  <= padOe_d;
            coreIn <= coreIn_d;
        end
    end

endmodule : bsp_pad_swap
`default_nettype wire

// ### hdl/bsp_pkg.sv
// bsp_pkg.sv: types shared by the strap/pin-mux block
// assumes: bsp_defines.svh on the include path
package bsp_pkg;
    typedef enum logic {BSP_CAPTURE, BSP_RUN} bsp_state_t;
    typedef enum logic {BSP_ROLE_DEVICE, BSP_ROLE_HOST} bsp_role_t;
endpackage : bsp_pkg

// ### hdl/bsp_strap_pinmux.sv
// bsp_strap_pinmux.sv: strap capture, rate control and shared-pin muxing of the bridge
// assumes: all inputs synchronous to mclk; rst_n is the chip-wide power-on reset
`timescale 1ns/10ps
`default_nettype none
`include "bsp_defines.svh"

module bsp_strap_pinmux
    import bsp_pkg::*;
#(
    parameter int N = `BSP_NUM_ATA
)(
    // clock and global reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // configuration straps
    input  wire logic [2:0]   opModeStrap,
    input  wire logic         fixed_udma_rate,
    input  wire logic         ata_output_enable,
    input  wire logic         power_mgmt_translate_enable,
    input  wire logic         spread_clock_enable,
    input  wire logic [1:0]   ref_clock_select,
    // decoded configuration
    output var  logic         hostRole,
    output var  logic         deviceOne,
    output var  logic         reverseOrder,
    output var  logic [1:0]   udmaCeiling,
    output var  logic [1:0]   udmaRate,
    output var  logic         sscOn,
    output var  logic         strapFault,
    // link state and power-management requests
    input  wire logic         phyCommUp,
    input  wire logic         pmCmdValid,
    input  wire logic         pmCmdSlumber,
    output var  logic         link_ready,
    output var  logic         partialReq,
    output var  logic         slumberReq,
    // set-features rate request
    input  wire logic         setFeatValid,
    input  wire logic [1:0]   setFeatRate,
    // protocol engine side
    input  wire logic [2:0]   pioMode,
    input  wire logic [7:0]   ataCtrlReg,
    input  wire logic         diagPhase,
    input  wire logic         devActive,
    input  wire logic         diagDone,
    input  wire logic [N-1:0] ataCoreOut,
    input  wire logic [N-1:0] ataCoreOe,
    output var  logic [N-1:0] ataCoreIn,
    output var  logic         slaveSeen,
    output var  logic         slaveDiagDone,
    // parallel ATA pads
    input  wire logic [N-1:0] ataPadIn,
    output var  logic [N-1:0] ataPadOut,
    output var  logic [N-1:0] ataPadOe,
    // master/slave select pin, shared output b
    input  wire logic         msSelIn,
    output var  logic         msSelOut,
    output var  logic         msSelOe,
    // diagnostic / pin-order pin
    input  wire logic         diagPinIn,
    output var  logic         diagPinOut,
    output var  logic         diagPinOe
);

    function automatic logic modeReserved(input logic [2:0] m);
        modeReserved = (m[1:0] == `BSP_RATE_BAD);
    endfunction : modeReserved

    function automatic logic rateLegal(input logic [1:0] r, input logic [1:0] ceil);
        rateLegal = (r != `BSP_RATE_BAD) && (r <= ceil);
    endfunction : rateLegal

    // ------------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------------
    bsp_state_t state_q;
    logic [2:0] mode_q;
    logic       fixed_q;
    logic       outEn_q;
    logic       power_mgmt_translate_enable_q;
    logic       devOne_q;
    logic       rev_q;
    logic [1:0] rate_q;
    logic       partial_q;
    logic       slumber_q;
    logic       link_q;
    logic       sscOn_q;
    logic       fault_q;
    logic       slaveSeen_q;
    logic       slaveDiag_q;
    logic       msOut_q;
    logic       msOe_q;
    logic       diagOut_q;
    logic       diagOe_q;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    wire        capture     = (state_q == BSP_CAPTURE);
    wire        strapBad    = modeReserved(opModeStrap) || (ref_clock_select != `BSP_REFCLK_25M);
    // reserved modes fall back to the default code rather than an undefined role
    wire [2:0]  modeSafe    = modeReserved(opModeStrap) ? `BSP_MODE_RESET : opModeStrap;
    wire        isHost      = mode_q[`BSP_MODE_HOST_BIT];
    wire [1:0]  ceil        = mode_q[1:0];
    wire        featTake    = !capture && !fixed_q && setFeatValid && rateLegal(setFeatRate, ceil);
    wire [1:0]  rate_d      = capture ? modeSafe[1:0] : (featTake ? setFeatRate : rate_q);
    wire        pmTake      = !capture && power_mgmt_translate_enable_q && pmCmdValid;
    wire        actAsserted = diagPhase ? 1'b1 : devActive;
    wire        hostDev1    = isHost && devOne_q;
    wire        hostDev0    = isHost && !devOne_q;

    // shared pads: control bits in device mode, presence/activity in host device1
    wire        actOut  = isHost ? !actAsserted : ataCtrlReg[`BSP_CTRL_BIT_A];
    wire        actOe   = !isHost || hostDev1;
    wire        spOut   = isHost ? 1'b1 : ataCtrlReg[`BSP_CTRL_BIT_C];
    wire        spOe    = !isHost || hostDev1;
    // ready only stretches from PIO 3 up; below that the pin is left undriven
    wire        rdyOe   = ataCoreOe[`BSP_IDX_RDY] && (pioMode >= `BSP_PIO_STRETCH_MIN);

    logic [N-1:0] muxOut;
    logic [N-1:0] muxOe;
    always_comb
    begin
        muxOut                = ataCoreOut;
        muxOe                 = ataCoreOe;
        muxOut[`BSP_IDX_ACTN] = actOut;
        muxOe[`BSP_IDX_ACTN]  = actOe;
        muxOut[`BSP_IDX_SPH]  = spOut;
        muxOe[`BSP_IDX_SPH]   = spOe;
        muxOe[`BSP_IDX_RDY]   = rdyOe;
    end

    // ------------------------------------------------------------------------
    // strap capture, held until the next reset
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= BSP_CAPTURE;
            mode_q   <= `BSP_MODE_RESET;
            fixed_q  <= 1'b0;
            outEn_q  <= 1'b0;
            power_mgmt_translate_enable_q   <= 1'b0;
            sscOn_q  <= 1'b0;
            fault_q  <= 1'b0;
            devOne_q <= 1'b0;
            rev_q    <= 1'b0;
        end
        else if (capture)
        begin
            state_q  <= BSP_RUN;
            mode_q   <= modeSafe;
            fixed_q  <= fixed_udma_rate;
            outEn_q  <= ata_output_enable;
            power_mgmt_translate_enable_q   <= power_mgmt_translate_enable;
            sscOn_q  <= spread_clock_enable;
            fault_q  <= strapBad;
            devOne_q <= modeSafe[`BSP_MODE_HOST_BIT] && msSelIn;
            rev_q    <= !modeSafe[`BSP_MODE_HOST_BIT] && diagPinIn;
        end
    end

    // ------------------------------------------------------------------------
    // rate, link and power-management requests
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_q    <= `BSP_RATE_150;
            link_q    <= 1'b0;
            partial_q <= 1'b0;
            slumber_q <= 1'b0;
        end
        else
        begin
            rate_q    <= rate_d;
            link_q    <= phyCommUp;
            partial_q <= pmTake && !pmCmdSlumber;
            slumber_q <= pmTake && pmCmdSlumber;
        end
    end

    // ------------------------------------------------------------------------
    // shared pins and diagnostic handshake
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msOut_q     <= 1'b0;
            msOe_q      <= 1'b0;
            diagOut_q   <= 1'b0;
            diagOe_q    <= 1'b0;
            slaveSeen_q <= 1'b0;
            slaveDiag_q <= 1'b0;
        end
        else
        begin
            msOut_q     <= ataCtrlReg[`BSP_CTRL_BIT_B];
            msOe_q      <= !capture && !isHost && outEn_q;
            diagOut_q   <= 1'b0;
            diagOe_q    <= !capture && hostDev1 && diagDone && outEn_q;
            slaveDiag_q <= hostDev0 && !diagPinIn;
            slaveSeen_q <= hostDev0 && (ataCoreIn[`BSP_IDX_SPH] || !ataCoreIn[`BSP_IDX_ACTN]);
        end
    end

    bsp_pad_swap #(
        .N            (N)
    ) u_swap (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .reverseOrder (rev_q),
        .outEnable    (outEn_q),
        .coreOut      (muxOut),
        .coreOe       (muxOe),
        .coreIn       (ataCoreIn),
        .padIn        (ataPadIn),
        .padOut       (ataPadOut),
        .padOe        (ataPadOe)
    );

    assign hostRole      = isHost;
    assign deviceOne     = devOne_q;
    assign reverseOrder  = rev_q;
    assign udmaCeiling   = mode_q[1:0];
    assign udmaRate      = rate_q;
    assign sscOn         = sscOn_q;
    assign strapFault    = fault_q;
    assign link_ready    = link_q;
    assign partialReq    = partial_q;
    assign slumberReq    = slumber_q;
    assign slaveSeen     = slaveSeen_q;
    assign slaveDiagDone = slaveDiag_q;
    assign msSelOut      = msOut_q;
    assign msSelOe       = msOe_q;
    assign diagPinOut    = diagOut_q;
    assign diagPinOe     = diagOe_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    strap_hold_a: assert property (!capture |=> $stable(mode_q) && $stable(rev_q) && $stable(outEn_q))
        else $error("straps changed after capture");
    mode_decode_a: assert property (capture && !modeReserved(opModeStrap) |=> mode_q == $past(opModeStrap))
        else $error("mode strap decoded wrongly");
    fixed_rate_a: assert property (!capture && fixed_q |=> rate_q == ceil)
        else $error("fixed rate moved off strap value");
    feat_rate_a: assert property (featTake |=> rate_q == $past(setFeatRate))
        else $error("set-features rate not taken");
    oe_gate_a: assert property (!outEn_q ##1 !outEn_q |-> ataPadOe == '0 && !msSelOe && !diagPinOe)
        else $error("pad driven while outputs disabled");
    pm_gate_a: assert property (!capture && !power_mgmt_translate_enable_q |=> !partialReq && !slumberReq)
        else $error("power request without enable");
    link_follow_a: assert property (phyCommUp |=> link_ready ##1 (link_ready == $past(phyCommUp)))
        else $error("link ready does not follow link");
    shared_bits_a: assert property (!capture && !isHost |=> msSelOut == $past(ataCtrlReg[4]))
        else $error("shared pin b not control bit");
    ready_pio_a: assert property (pioMode < 3'h3 |=> !ataPadOe[`BSP_IDX_RDY])
        else $error("ready driven below pio 3");
    host_dev0_a: assert property (hostDev0 ##1 hostDev0 |-> !ataPadOe[`BSP_IDX_ACTN] && !ataPadOe[`BSP_IDX_SPH])
        else $error("device0 drives presence pins");
    host_select_a: assert property (capture |=> deviceOne == (hostRole && $past(msSelIn)))
        else $error("device select not captured");
    pin_order_a: assert property (capture |=> reverseOrder == (!hostRole && $past(diagPinIn)))
        else $error("pin order not captured");
    ssc_strap_a: assert property (capture |=> sscOn == $past(spread_clock_enable))
        else $error("spread clock strap not captured");
    slave_flag_a: assert property (hostDev1 && outEn_q |=> ataPadOut[`BSP_IDX_SPH] && ataPadOe[`BSP_IDX_SPH])
        else $error("device1 not flagging presence");
    act_drive_a: assert property (hostDev1 |=> ataPadOut[`BSP_IDX_ACTN] == !$past(diagPhase || devActive))
        else $error("activity pad wrong");
    diag_done_a: assert property (hostDev1 && diagDone && outEn_q |=> diagPinOe && !diagPinOut)
        else $error("diagnostics done not driven");
    shared_sp_a: assert property (!isHost && !rev_q |=> ataPadOut[`BSP_IDX_SPH] == $past(ataCtrlReg[5]))
        else $error("shared pin c not control bit");

endmodule : bsp_strap_pinmux
`default_nettype wire

// ### tb/bsp_ata_peer.sv
// bsp_ata_peer.sv: far-side parallel ATA party, resolves every shared pad
// assumes: bench sets the peer enables and values just after a clock edge
`timescale 1ns/10ps
`default_nettype none

module bsp_ata_peer
#(
    parameter int N = 30
)(
    // clock
    input  wire logic         mclk,
    // design pad side
    input  wire logic [N-1:0] padOut,
    input  wire logic [N-1:0] padOe,
    output var  logic [N-1:0] padIn,
    input  wire logic         msSelOut,
    input  wire logic         msSelOe,
    output var  logic         msSelIn,
    input  wire logic         diagPinOut,
    input  wire logic         diagPinOe,
    output var  logic         diagPinIn,
    // peer drive controls
    input  wire logic [N-1:0] peerEn,
    input  wire logic [N-1:0] peerVal,
    input  wire logic         msEn,
    input  wire logic         msVal,
    input  wire logic         diagEn,
    input  wire logic         diagVal
);
    logic [N-1:0] lastQ = '0;

    // ------------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------------
    // undriven pads without pull flip, so a stale value never passes
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (padOe[i])
                padIn[i] = padOut[i];
            else if (peerEn[i])
                padIn[i] = peerVal[i];
            else if (i == 27)
                padIn[i] = 1'b0;
            else if (i == 29)
                padIn[i] = 1'b1;
            else
                padIn[i] = ~lastQ[i];
        end
    end

    always_ff @(posedge mclk)
        lastQ <= padIn;

    assign msSelIn   = msSelOe ? msSelOut : (msEn ? msVal : 1'b0);
    assign diagPinIn = diagPinOe ? diagPinOut : (diagEn ? diagVal : 1'b1);

endmodule : bsp_ata_peer

`default_nettype wire

// ### tb/tb_top.sv
// tb_top.sv: self-checking bench for the strap/pin-mux block
// assumes: bsp_pkg and bsp_defines.svh compiled first, peer model beside it
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import bsp_pkg::*;
    localparam int N = 30;
    logic mclk, rst_n, fixed_udma_rate, ata_output_enable, power_mgmt_translate_enable;
    logic spread_clock_enable, phyCommUp, pmCmdValid, pmCmdSlumber, setFeatValid;
    logic diagPhase, devActive, diagDone, msSelIn, diagPinIn, msEn, msVal, diagEn, diagVal;
    logic [2:0] opModeStrap, pioMode;
    logic [1:0] ref_clock_select, setFeatRate;
    logic [7:0] ataCtrlReg;
    logic [N-1:0] ataCoreOut, ataCoreOe, ataCoreIn, ataPadIn, ataPadOut, ataPadOe, peerEn, peerVal;
    logic hostRole, deviceOne, reverseOrder, sscOn, strapFault, link_ready, partialReq, slumberReq;
    logic slaveSeen, slaveDiagDone, msSelOut, msSelOe, diagPinOut, diagPinOe;
    logic [1:0] udmaCeiling, udmaRate;
    int n_mismatch, compares, cycles, expRate;
    int seed = 32'h0179;

    bsp_strap_pinmux #(.N(N)) u_dut (.mclk, .rst_n, .opModeStrap, .fixed_udma_rate, .ata_output_enable,
        .power_mgmt_translate_enable, .spread_clock_enable, .ref_clock_select, .hostRole, .deviceOne,
        .reverseOrder, .udmaCeiling, .udmaRate, .sscOn, .strapFault, .phyCommUp, .pmCmdValid, .pmCmdSlumber,
        .link_ready, .partialReq, .slumberReq, .setFeatValid, .setFeatRate, .pioMode, .ataCtrlReg, .diagPhase,
        .devActive, .diagDone, .ataCoreOut, .ataCoreOe, .ataCoreIn, .slaveSeen, .slaveDiagDone, .ataPadIn,
        .ataPadOut, .ataPadOe, .msSelIn, .msSelOut, .msSelOe, .diagPinIn, .diagPinOut, .diagPinOe);
    bsp_ata_peer #(.N(N)) u_peer (.mclk, .padOut(ataPadOut), .padOe(ataPadOe), .padIn(ataPadIn), .msSelOut,
        .msSelOe, .msSelIn, .diagPinOut, .diagPinOe, .diagPinIn, .peerEn, .peerVal, .msEn, .msVal, .diagEn,
        .diagVal);

    // ------------------------------------------------------------------
    // clock, timeout, shared tasks
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("[ERR] run did not finish in time");
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // straps and pin levels held through reset, pins released after capture
    task automatic strap_reset(input logic [2:0] m, input logic fx, oen, ms, dg);
        rst_n = 1'b0;
        opModeStrap = m;
        fixed_udma_rate = fx;
        ata_output_enable = oen;
        {msEn, msVal, diagEn, diagVal} = {1'b1, ms, 1'b1, dg};
        step(16);
        rst_n = 1'b1;
        step(1);
        {msEn, diagEn} = 2'h0;
        step(2);
    endtask : strap_reset

    function automatic int mir(input int i);
        int t[30] = '{13,14,15,22,23,27,18,16,20,19,25,21,24,0,1,2,7,26,6,9,8,11,3,4,12,10,17,5,28,29};
        return t[i];
    endfunction : mir

    // back-to-back requests, random codes after a first legal one
    task automatic rate_burst(input int ceil, input logic fx);
        int r;
        setFeatValid = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            r = (i == 0) ? 0 : ($random(seed) & 3);
            setFeatRate = r[1:0];
            step(1);
            if (!fx && r != 3 && r <= ceil)
                expRate = r;
            chk("udmaRate", expRate, udmaRate);
        end
        setFeatValid = 1'b0;
    endtask : rate_burst

    task automatic pad_check(input logic rv, oen);
        logic [31:0] eo, eoe, ei, mk;
        int k;
        {eo, eoe, ei, mk} = '0;
        for (int i = 0; i < 27; i++)
        begin
            k = rv ? mir(i) : i;
            if (i != 5)
                {mk[i], eo[i], eoe[i], ei[i]} = {1'b1, ataCoreOut[k], ataCoreOe[k] & oen, ataPadIn[k]};
        end
        chk("padOut", eo, ataPadOut & mk);
        chk("padOe", eoe, ataPadOe & mk);
        chk("coreIn", ei, ataCoreIn & mk);
        chk("activityPad", ataCtrlReg[3], ataPadOut[29]);
        chk("msSelOut", ataCtrlReg[4], msSelOut);
        chk("readyOe", oen && pioMode >= 3, ataPadOe[28]);
        if (!oen)
            chk("allOe", 0, ataPadOe);
        chk("spPad", ataCtrlReg[5], ataPadOut[rv ? 5 : 27]);
        chk("msSelOe", oen, msSelOe);
    endtask : pad_check

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, fixed_udma_rate, ata_output_enable, power_mgmt_translate_enable, spread_clock_enable} = 5'h0F;
        {phyCommUp, pmCmdValid, pmCmdSlumber, setFeatValid, diagPhase, devActive, diagDone} = 7'h00;
        {opModeStrap, pioMode, ref_clock_select, setFeatRate, ataCtrlReg} = 18'h00400;
        {ataCoreOut, ataCoreOe, peerEn, peerVal} = '0;
        {msEn, msVal, diagEn, diagVal} = 4'h0;
        for (int m = 0; m < 8; m++)
        begin
            spread_clock_enable = m[0];
            strap_reset(m[2:0], 1'b0, 1'b1, 1'b0, 1'b0);
            chk("hostRole", m[2] && m != 7, hostRole);
            chk("udmaCeiling", (m == 3 || m == 7) ? 2 : m[1:0], udmaCeiling);
            chk("strapFault", m == 3 || m == 7, strapFault);
            chk("sscOn", m[0], sscOn);
            opModeStrap = ~m[2:0];
            spread_clock_enable = ~m[0];
            step(2);
            chk("heldRole", m[2] && m != 7, hostRole);
            chk("heldSsc", m[0], sscOn);
        end
        ref_clock_select = 2'h2;
        strap_reset(3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("refFault", 1, strapFault);
        ref_clock_select = 2'h1;
        $display("test straps done");
        strap_reset(3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        rate_burst(2, 1'b0);
        strap_reset(3'h4, 1'b0, 1'b1, 1'b0, 1'b0);
        rate_burst(0, 1'b0);
        strap_reset(3'h5, 1'b1, 1'b1, 1'b0, 1'b0);
        expRate = 1;
        rate_burst(1, 1'b1);
        $display("test rates done");
        for (int p = 1; p >= 0; p--)
        begin
            power_mgmt_translate_enable = p[0];
            strap_reset(3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
            {pmCmdValid, pmCmdSlumber, phyCommUp} = 3'h7;
            step(1);
            chk("slumberReq", p, slumberReq);
            chk("linkUp", 1, link_ready);
            {pmCmdSlumber, phyCommUp} = 2'h0;
            step(1);
            chk("partialReq", p, partialReq);
            chk("linkDown", 0, link_ready);
            pmCmdValid = 1'b0;
            step(1);
            chk("reqIdle", 0, {partialReq, slumberReq});
        end
        $display("test power and link done");
        for (int c = 0; c < 4; c++)
        begin
            strap_reset(3'h2, 1'b0, c < 2, 1'b0, c[0]);
            chk("reverseOrder", c[0], reverseOrder);
            ataCoreOut = 30'($random(seed));
            ataCoreOe = 30'($random(seed)) | 30'h10000000;
            {peerEn, peerVal} = {30'h3FFFFFFF, 30'($random(seed))};
            {ataCtrlReg, pioMode} = 11'($random(seed));
            step(3);
            pad_check(c[0], c < 2);
        end
        $display("test device pads done");
        strap_reset(3'h4, 1'b0, 1'b1, 1'b1, 1'b1);
        chk("deviceOne", 3'h6, {hostRole, deviceOne, reverseOrder});
        for (int d = 0; d < 3; d++)
        begin
            {diagPhase, devActive} = (d == 0) ? 2'h2 : ((d == 1) ? 2'h1 : 2'h0);
            step(2);
            chk("activityOut", d == 2, ataPadOut[29]);
            chk("spOut", 3'h7, {ataPadOe[29], ataPadOut[27], ataPadOe[27]});
        end
        diagDone = 1'b1;
        step(2);
        chk("diagPin", 2'h2, {diagPinOe, diagPinOut});
        strap_reset(3'h6, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("deviceZero", 3'h0, {deviceOne, ataPadOe[29], ataPadOe[27]});
        for (int s = 0; s < 3; s++)
        begin
            peerVal[29:27] = (s == 0) ? 3'h5 : ((s == 1) ? 3'h0 : 3'h4);
            step(3);
            chk("slaveSeen", s < 2, slaveSeen);
        end
        {diagEn, diagVal} = 2'h2;
        step(2);
        chk("slaveDiagDone", 1, slaveDiagDone);
        diagVal = 1'b1;
        step(2);
        chk("slaveDiagIdle", 0, slaveDiagDone);
        $display("test host pins done");
        close_out();
    end

endmodule : tb_top

`default_nettype wire
